// file: hw/ecr_regs.vh
// Register offsets, field positions and reset values of the express capability register bank.
`ifndef ECR_REGS_VH
`define ECR_REGS_VH
`define ECR_ADDR_W 12
`define ECR_OFS_CAP_HDR 12'h040
`define ECR_OFS_DEV_CAP 12'h044
`define ECR_OFS_CTRL 12'h048
`define ECR_CAP_ID 8'h10
`define ECR_NEXT_LINK_RST 8'hC0
`define ECR_VERSION_RST 4'h2
`define ECR_TYPE_UP 4'h5
`define ECR_TYPE_DOWN 4'h6
`define ECR_PAYLOAD_RST 3'h4
`define ECR_XTAG_RST 1'h1
`define ECR_ROLE_ERR 1'h1
`define ECR_POWER_RST 8'h00
`define ECR_SCALE_RST 2'h0
`define ECR_SLOT_RST 1'h0
`define ECR_LOCK_RST 1'h1
`define ECR_CTRL_LOCK_BIT 0
`define ECR_CTRL_SLOT_BIT 1
`define ECR_NEXT_LSB 8
`define ECR_NEXT_MSB 15
`define ECR_VER_LSB 16
`define ECR_VER_MSB 19
`define ECR_SLOT_BIT 24
`define ECR_PAYLOAD_LSB 0
`define ECR_PAYLOAD_MSB 2
`define ECR_XTAG_BIT 5
`define ECR_ZERO32 32'h00000000
`endif

// file: hw/ecr_express_capability_regs.v
// Express capability header and device capabilities register bank for one switch port.
`timescale 1ns/10ps
`default_nettype none
// Function
// (R1) Header bits 7:0 read-only, always return capability identifier 0x10.
// (R2) Header bits 15:8 next capability link, reset 0xC0, locked-write only.
// (R3) Header bits 19:16 structure version, reset 2, locked-write only.
// (R4) Port type bits 23:20 read 5 upstream, 6 downstream.
// (R5) Software sets slot-present bit only for slot links; zero upstream. The bank does not force it: an upstream port can write it too.
// (R6) Interrupt message index bits 29:25 always read zero.
// (R7) Payload supported bits 2:0 reset 4, locked-write only.
// (R8) Phantom function support bits 4:3 hardwired zero.
// (R9) Extended tag bit 5 resets to 1, locked-write only.
// (R10) L0s and L1 latency tolerance fields hardwired zero.
// (R11) Attention button, attention indicator, power indicator bits read zero.
// (R12) Bit 15 reads one for role-based error reporting.
// (R13) Upstream captures power value 25:18 from each message; downstream holds zero.
// (R14) Software computes watts as value times selected scale factor.
// (R15) Scale 27:26 captured upstream only; codes select 1, 0.1, 0.01, 0.001.
// (R16) Software keeps payload setting no higher than supported payload field.
// (R17) Reserved bits read zero and ignore writes.
// (R18) Ordinary writes leave read-only fields alone; captured power resets to zero.
`include "ecr_regs.vh"
// The register bus answers every access after one wait cycle: a request seen at one edge
// drops waitrequest for the next cycle, and a write lands at the edge where the master
// sees waitrequest low. After an answer one idle cycle passes before the next accept.
// The lock register at the control offset gates every locked-write field. It resets
// locked; software clears it, writes the header or device capabilities, and sets it
// again. While it is clear, a control write also updates the slot-present bit.
// Received slot power messages load the captured value and scale on the upstream port
// only; a downstream port keeps both at zero, and both return to zero on reset.
module ecr_express_capability_regs
#(
	parameter IS_UPSTREAM = 1
)
(
	input wire REF_CLK,
	input wire RST,
	input wire [`ECR_ADDR_W-1:0] ADDRESS,
	input wire READ,
	input wire WRITE,
	input wire [31:0] WRITEDATA,
	input wire [3:0] BYTEENABLE,
	output reg [31:0] READDATA,
	output reg WAITREQUEST,
	input wire POWER_MSG_VALID,
	input wire [7:0] POWER_MSG_VALUE,
	input wire [1:0] POWER_MSG_SCALE,
	output reg [2:0] PAYLOAD_SUPPORTED,
	output reg [7:0] POWER_LIMIT_VALUE,
	output reg [1:0] POWER_LIMIT_SCALE
);
	reg [7:0] next_capability_link_ff;
	reg [3:0] structure_version_ff;
	reg slot_present_ff;
	reg [2:0] largest_payload_supported_ff;
	reg extended_tag_support_ff;
	reg [7:0] captured_power_limit_value_ff;
	reg [1:0] captured_power_limit_scale_ff;
	reg locked_ff;
	reg done_ff;
	wire [3:0] port_type;
	wire access;
	wire accept;
	wire wr_hdr;
	wire wr_dev;
	wire wr_ctrl;
	reg [31:0] nxt_readdata;
	reg [7:0] nxt_next_capability_link;
	reg [3:0] nxt_structure_version;
	reg nxt_slot_present;
	reg [2:0] nxt_largest_payload_supported;
	reg nxt_extended_tag_support;
	reg [7:0] nxt_captured_power_limit_value;
	reg [1:0] nxt_captured_power_limit_scale;
	reg nxt_locked;
	reg nxt_done;
	reg nxt_waitrequest;
	wire commit;
	wire sel_hdr;
	wire sel_dev;
	wire sel_ctrl;

	// ------------------------------------------------------------
	// Field images.
	// ------------------------------------------------------------
	function [3:0] port_kind;
		input up;
		begin
			if (up)
			begin
				port_kind = `ECR_TYPE_UP;
			end
			else
			begin
				port_kind = `ECR_TYPE_DOWN;
			end
		end
	endfunction

	assign port_type = port_kind(IS_UPSTREAM != 0); // [R4]

	function [31:0] hdr_image;
		input [7:0] link;
		input [3:0] structure_version;
		input [3:0] ptype;
		input slot;
		begin
			// Reserved 31:30 and message index 29:25 read zero. [R6] [R17]
			hdr_image = {
				2'h0,
				5'h00,
				slot,
				ptype,
				structure_version,
				link,
				`ECR_CAP_ID
			}; // [R1] [R2] [R3]
		end
	endfunction

	function [31:0] dev_image;
		input [2:0] payload;
		input xtag;
		input [7:0] pval;
		input [1:0] pscale;
		begin
			// Latency, presence flags and phantom bits are zero. [R8] [R10] [R11] [R17]
			dev_image = {
				4'h0,
				pscale,
				pval,
				2'h0,
				`ECR_ROLE_ERR,
				3'h0,
				3'h0,
				3'h0,
				xtag,
				2'h0,
				payload
			}; // [R12]
		end
	endfunction

	function addr_match;
		input [`ECR_ADDR_W-1:0] addr;
		input [`ECR_ADDR_W-1:0] ofs;
		begin
			addr_match = (addr == ofs);
		end
	endfunction

	function [31:0] ctrl_image;
		input slot;
		input locked;
		begin
			// Only the lock and slot alias bits exist; the rest reads zero. [R17]
			ctrl_image = {30'h00000000, slot, locked};
		end
	endfunction

	// ------------------------------------------------------------
	// Avalon slave: one wait cycle, then the access completes.
	// ------------------------------------------------------------
	assign access = READ | WRITE;
	assign accept = access & ~done_ff;
	// Writes land at the edge where the master sees waitrequest low.
	assign commit = WRITE & done_ff;
	assign sel_hdr = addr_match(ADDRESS, `ECR_OFS_CAP_HDR);
	assign sel_dev = addr_match(ADDRESS, `ECR_OFS_DEV_CAP);
	assign sel_ctrl = addr_match(ADDRESS, `ECR_OFS_CTRL);
	assign wr_hdr = commit & sel_hdr;
	assign wr_dev = commit & sel_dev;
	assign wr_ctrl = commit & sel_ctrl;

	always @*
	begin
		if (sel_hdr)
		begin
			nxt_readdata = hdr_image(next_capability_link_ff, structure_version_ff, port_type, slot_present_ff);
		end
		else if (sel_dev)
		begin
			nxt_readdata = dev_image(largest_payload_supported_ff, extended_tag_support_ff,
				captured_power_limit_value_ff, captured_power_limit_scale_ff);
		end
		else if (sel_ctrl)
		begin
			nxt_readdata = ctrl_image(slot_present_ff, locked_ff);
		end
		else
		begin
			nxt_readdata = `ECR_ZERO32;
		end
	end

	always @*
	begin
		nxt_done = accept;
		nxt_waitrequest = ~accept;
	end

	// ------------------------------------------------------------
	// Bus handshake registers.
	// ------------------------------------------------------------
	always @(posedge REF_CLK)
	begin
		if (RST)
		begin
			done_ff <= 1'b0;
			WAITREQUEST <= 1'b1;
			READDATA <= `ECR_ZERO32;
		end
		else
		begin
			done_ff <= nxt_done;
			WAITREQUEST <= nxt_waitrequest;
			if (accept && READ)
			begin
				READDATA <= nxt_readdata;
			end
		end
	end

	// ------------------------------------------------------------
	// Locked-write fields: writable only while the lock is open.
	// ------------------------------------------------------------
	always @*
	begin
		// Fields other than the lock keep their value unless a write lands while unlocked.
		nxt_locked = locked_ff;
		nxt_next_capability_link = next_capability_link_ff;
		nxt_structure_version = structure_version_ff;
		nxt_slot_present = slot_present_ff;
		nxt_largest_payload_supported = largest_payload_supported_ff;
		nxt_extended_tag_support = extended_tag_support_ff;
		if (wr_ctrl && BYTEENABLE[0])
		begin
			nxt_locked = WRITEDATA[`ECR_CTRL_LOCK_BIT];
			// Slot presence mirrors the header bit for software convenience.
			if (!locked_ff)
			begin
				nxt_slot_present = WRITEDATA[`ECR_CTRL_SLOT_BIT]; // [R5]
			end
		end
		if (wr_hdr && !locked_ff)
		begin
			if (BYTEENABLE[1])
			begin
				nxt_next_capability_link = WRITEDATA[`ECR_NEXT_MSB:`ECR_NEXT_LSB]; // [R2] [R18]
			end
			if (BYTEENABLE[2])
			begin
				nxt_structure_version = WRITEDATA[`ECR_VER_MSB:`ECR_VER_LSB]; // [R3]
			end
			if (BYTEENABLE[3])
			begin
				nxt_slot_present = WRITEDATA[`ECR_SLOT_BIT]; // [R5]
			end
		end
		if (wr_dev && !locked_ff && BYTEENABLE[0])
		begin
			nxt_largest_payload_supported = WRITEDATA[`ECR_PAYLOAD_MSB:`ECR_PAYLOAD_LSB]; // [R7] [R16]
			nxt_extended_tag_support = WRITEDATA[`ECR_XTAG_BIT]; // [R9]
		end
	end

	// ------------------------------------------------------------
	// Locked-write field registers.
	// ------------------------------------------------------------
	always @(posedge REF_CLK)
	begin
		if (RST)
		begin
			locked_ff <= `ECR_LOCK_RST;
			next_capability_link_ff <= `ECR_NEXT_LINK_RST;
			structure_version_ff <= `ECR_VERSION_RST;
			slot_present_ff <= `ECR_SLOT_RST;
			largest_payload_supported_ff <= `ECR_PAYLOAD_RST;
			extended_tag_support_ff <= `ECR_XTAG_RST;
		end
		else
		begin
			locked_ff <= nxt_locked;
			next_capability_link_ff <= nxt_next_capability_link;
			structure_version_ff <= nxt_structure_version;
			slot_present_ff <= nxt_slot_present;
			largest_payload_supported_ff <= nxt_largest_payload_supported;
			extended_tag_support_ff <= nxt_extended_tag_support;
		end
	end

	// ------------------------------------------------------------
	// Slot power limit capture from received messages.
	// ------------------------------------------------------------
	always @*
	begin
		// A downstream port never loads the fields, so they stay at their reset zero.
		nxt_captured_power_limit_value = captured_power_limit_value_ff;
		nxt_captured_power_limit_scale = captured_power_limit_scale_ff;
		if (POWER_MSG_VALID && (IS_UPSTREAM != 0))
		begin
			nxt_captured_power_limit_value = POWER_MSG_VALUE; // [R13]
			nxt_captured_power_limit_scale = POWER_MSG_SCALE; // [R15] [R14]
		end
	end

	// ------------------------------------------------------------
	// Captured power registers.
	// ------------------------------------------------------------
	always @(posedge REF_CLK)
	begin
		if (RST)
		begin
			captured_power_limit_value_ff <= `ECR_POWER_RST; // [R18]
			captured_power_limit_scale_ff <= `ECR_SCALE_RST;
		end
		else
		begin
			captured_power_limit_value_ff <= nxt_captured_power_limit_value;
			captured_power_limit_scale_ff <= nxt_captured_power_limit_scale;
		end
	end

	// ------------------------------------------------------------
	// Registered copies for the rest of the port.
	// ------------------------------------------------------------
	always @(posedge REF_CLK)
	begin
		if (RST)
		begin
			PAYLOAD_SUPPORTED <= `ECR_PAYLOAD_RST;
			POWER_LIMIT_VALUE <= `ECR_POWER_RST;
			POWER_LIMIT_SCALE <= `ECR_SCALE_RST;
		end
		else
		begin
			PAYLOAD_SUPPORTED <= largest_payload_supported_ff;
			POWER_LIMIT_VALUE <= captured_power_limit_value_ff;
			POWER_LIMIT_SCALE <= captured_power_limit_scale_ff;
		end
	end
endmodule
`default_nettype wire

// file: dv/ecr_regs_checker.sv
// Port assertions for the express capability register bank.
`timescale 1ns/10ps
`default_nettype none
module ecr_regs_checker
#(
	parameter IS_UPSTREAM = 1
)
(
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic [11:0] ADDRESS,
	input wire logic READ,
	input wire logic WAITREQUEST,
	input wire logic [31:0] READDATA,
	input wire logic POWER_MSG_VALID,
	input wire logic [7:0] POWER_MSG_VALUE,
	input wire logic [1:0] POWER_MSG_SCALE,
	input wire logic [7:0] POWER_LIMIT_VALUE,
	input wire logic [1:0] POWER_LIMIT_SCALE
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);
	wire logic hd = READ && !WAITREQUEST && ADDRESS == 12'h040;
	wire logic dc = READ && !WAITREQUEST && ADDRESS == 12'h044;
	chk_wait_pulse: assert property (!WAITREQUEST |=> WAITREQUEST) else $error("long answer");
	chk_cap_ident: assert property (hd |-> READDATA[7:0] == 8'h10) else $error("bad id");
	chk_port_kind: assert property (hd |-> READDATA[23:20] == (IS_UPSTREAM ? 4'h5 : 4'h6)) else $error("bad type");
	chk_hdr_zero: assert property (hd |-> READDATA[31:25] == 7'h00) else $error("bad top");
	chk_dcap_fixed: assert property (dc |-> {READDATA[31:28], READDATA[17:16], READDATA[11:6], READDATA[4:3]} == 14'h0)
		else $error("bad zeros");
	chk_dcap_flags: assert property (dc |-> READDATA[15:12] == 4'h8) else $error("bad flags");
	chk_power_val: assert property (POWER_MSG_VALID |-> ##2
		POWER_LIMIT_VALUE == (IS_UPSTREAM ? $past(POWER_MSG_VALUE, 2) : 8'h00)) else $error("bad value");
	chk_power_scale: assert property (POWER_MSG_VALID |-> ##2
		POWER_LIMIT_SCALE == (IS_UPSTREAM ? $past(POWER_MSG_SCALE, 2) : 2'h0)) else $error("bad scale");
	chk_reset_clear: assert property (disable iff (1'b0) RST |=>
		POWER_LIMIT_VALUE == 8'h00 && POWER_LIMIT_SCALE == 2'h0 && WAITREQUEST) else $error("bad reset");
	cover property (hd);
	cover property (dc);
	cover property (POWER_MSG_VALID ##2 POWER_LIMIT_SCALE == 2'h3);
endmodule
bind ecr_express_capability_regs ecr_regs_checker #(.IS_UPSTREAM(IS_UPSTREAM)) u_chk (.REF_CLK(REF_CLK),
	.RST(RST), .ADDRESS(ADDRESS), .READ(READ), .WAITREQUEST(WAITREQUEST), .READDATA(READDATA),
	.POWER_MSG_VALID(POWER_MSG_VALID), .POWER_MSG_VALUE(POWER_MSG_VALUE), .POWER_MSG_SCALE(POWER_MSG_SCALE),
	.POWER_LIMIT_VALUE(POWER_LIMIT_VALUE), .POWER_LIMIT_SCALE(POWER_LIMIT_SCALE));
`default_nettype wire

// file: dv/ecr_express_capability_regs_tb.sv
// Self-checking bench for the express capability register bank.
`timescale 1ns/10ps
`default_nettype none
module ecr_express_capability_regs_tb;
	logic clk = 0, rst = 1, rd = 0, wr = 0, mv = 0, wt, wt2;
	logic [11:0] adr = 0;
	logic [31:0] wd = 0, q, rdat, q2, rdat2;
	logic [7:0] pv = 0, lv, lv2;
	logic [1:0] ps = 0, ls, ls2;
	logic [2:0] pay, pay2;
	int failures = 0, check_count = 0;
	ecr_express_capability_regs #(.IS_UPSTREAM(1)) DUT (.REF_CLK(clk), .RST(rst), .ADDRESS(adr), .READ(rd),
		.WRITE(wr), .WRITEDATA(wd), .BYTEENABLE(4'hF), .READDATA(rdat), .WAITREQUEST(wt),
		.POWER_MSG_VALID(mv), .POWER_MSG_VALUE(pv), .POWER_MSG_SCALE(ps), .PAYLOAD_SUPPORTED(pay),
		.POWER_LIMIT_VALUE(lv), .POWER_LIMIT_SCALE(ls));
	ecr_express_capability_regs #(.IS_UPSTREAM(0)) DUT_DOWN (.REF_CLK(clk), .RST(rst), .ADDRESS(adr), .READ(rd),
		.WRITE(wr), .WRITEDATA(wd), .BYTEENABLE(4'hF), .READDATA(rdat2), .WAITREQUEST(wt2),
		.POWER_MSG_VALID(mv), .POWER_MSG_VALUE(pv), .POWER_MSG_SCALE(ps), .PAYLOAD_SUPPORTED(pay2),
		.POWER_LIMIT_VALUE(lv2), .POWER_LIMIT_SCALE(ls2));
	initial forever #25 clk = ~clk;
	task wrap_up;
		if (failures == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One Avalon access; the request stands until waitrequest is seen low.
	task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		do @(posedge clk); while (wt !== 1'b0);
		q = rdat;
		q2 = rdat2;
		rd <= 0;
		wr <= 0;
		chk("waitrequest", 32'h0, {31'h0, wt});
		chk("down waitrequest", 32'h0, {31'h0, wt2});
	endtask
	task rc(input logic [11:0] a, input logic [31:0] e, input string nm);
		acc(0, a, 32'h0);
		chk(nm, e, q);
	endtask
	task do_reset;
		@(posedge clk);
		rst <= 1;
		repeat (10) @(posedge clk);
		rst <= 0;
	endtask
	task t_defaults;
		rc(12'h040, 32'h0052C010, "header");
		chk("down header", 32'h0062C010, q2);
		rc(12'h044, 32'h00008024, "devcaps");
		chk("down devcaps", 32'h00008024, q2);
		rc(12'h100, 32'h0, "unmapped");
		chk("outputs", {19'h0, 3'h4, 10'h0}, {19'h0, pay, lv, ls});
		chk("down outputs", {19'h0, 3'h4, 10'h0}, {19'h0, pay2, lv2, ls2});
	endtask
	task t_locked;
		acc(1, 12'h040, 32'hFFFFFFFF);
		acc(1, 12'h044, 32'hFFFFFFFF);
		acc(1, 12'h100, 32'hFFFFFFFF);
		t_defaults;
	endtask
	task t_power;
		for (logic [2:0] i = 0; i < 4; i++)
		begin
			@(posedge clk);
			mv <= 1;
			pv <= {6'h3F, i[1:0]};
			ps <= i[1:0];
			@(posedge clk);
			mv <= 0;
			rc(12'h044, {4'h0, i[1:0], 6'h3F, i[1:0], 18'h08024}, "captured");
			chk("down captured", 32'h00008024, q2);
			chk("copies", {22'h0, 6'h3F, i[1:0], i[1:0]}, {22'h0, lv, ls});
			chk("down copies", 32'h0, {22'h0, lv2, ls2});
		end
	endtask
	task t_unlock;
		acc(1, 12'h048, 32'h0);
		acc(1, 12'h040, 32'hFEF3A5EF);
		rc(12'h040, 32'h0053A510, "open header");
		acc(1, 12'h044, 32'hFFFFFFFF);
		rc(12'h044, 32'h0FFC8027, "open devcaps");
		chk("payload", 32'h7, {29'h0, pay});
		acc(1, 12'h044, 32'h0);
		acc(1, 12'h048, 32'h1);
		acc(1, 12'h044, 32'hFFFFFFFF);
		rc(12'h044, 32'h0FFC8000, "relocked");
	endtask
	initial
	begin
		do_reset;
		t_defaults;
		t_locked;
		t_power;
		t_unlock;
		do_reset;
		t_defaults;
		wrap_up;
	end
	initial
	begin
		#200000;
		failures++;
		wrap_up;
	end
endmodule
`default_nettype wire
